//--- bms_cfg.svh
// Constants for the beacon mode sequencer: offsets, fields, resets, timing
// Assumes inclusion by the sequencer module and the bench, not by bms_pkg.sv
`ifndef BMS_CFG_SVH
`define BMS_CFG_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define BMS_OFF_CTRL      8'h00
`define BMS_OFF_CFG_TMO   8'h04
`define BMS_OFF_ACT_TMO   8'h08
`define BMS_OFF_ACCEL     8'h0C
`define BMS_OFF_STATUS    8'h10
`define BMS_OFF_EVENT     8'h14
`define BMS_OFF_MEM_ADDR  8'h18
`define BMS_OFF_MEM_DATA  8'h1C
// ----------------------------------------
// Control fields
// ----------------------------------------
`define BMS_CTRL_ACT_SRC_LSB  0
`define BMS_CTRL_SW_RESET     2
`define BMS_CTRL_SVC_RESET    3
// ----------------------------------------
// Accelerometer configuration fields
// ----------------------------------------
`define BMS_ACC_RATE_LSB   0
`define BMS_ACC_POWER_BIT  4
`define BMS_ACC_NOISE_BIT  5
`define BMS_ACC_BW_LSB     6
`define BMS_ACC_RANGE_LSB  8
`define BMS_ACC_FILT_BIT   10
`define BMS_ACC_THR_LSB    11
`define BMS_ACC_DUR_LSB    17
`define BMS_ACC_6D_BIT     19
`define BMS_ACC_6DTHR_LSB  20
// Rate codes: 0 off, 1 1.6, 2 12.5, 3 25, 4 50, 5 100, 6 200, 7 400, 8 800, 9 1600 Hz
`define BMS_RATE_12P5      4'h2
`define BMS_RATE_MAX_LP    4'h6
`define BMS_RATE_MAX_HP    4'h9
`define BMS_ACC_RESET      32'h00000002
`define BMS_ACC_MASK       32'h00FFFFFF
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define BMS_CFG_TMO_RESET  32'h0000003C
`define BMS_ACT_TMO_RESET  32'h0000000A
`define BMS_CLK_HZ         40000000
`define BMS_TICK_HZ        8
`define BMS_TICK_DIV       (`BMS_CLK_HZ / `BMS_TICK_HZ)
`define BMS_FLASH_ON_MS    100
`define BMS_FLASH_OFF_MS   150
`define BMS_FLASH_ON_CYC   ((`BMS_FLASH_ON_MS * (`BMS_CLK_HZ / 1000)))
`define BMS_FLASH_OFF_CYC  ((`BMS_FLASH_OFF_MS * (`BMS_CLK_HZ / 1000)))
`define BMS_SELFTEST_FLASH 3'h1
`define BMS_MEM_DEPTH      16
`define BMS_MEM_AW         4
`endif

//--- bms_pkg.sv
// Types for the beacon mode sequencer
// Assumes bms_cfg.svh holds all numbers
package bms_pkg;
    typedef enum logic [2:0] {
        BMS_SELF_TEST = 3'b000,
        BMS_WAREHOUSE = 3'b001,
        BMS_INACTIVE  = 3'b010,
        BMS_ACTIVE    = 3'b011,
        BMS_CONFIG    = 3'b100,
        BMS_CLEAR     = 3'b101
    } bms_mode_t;
    typedef enum logic [1:0] {
        BMS_LED_NONE  = 2'b00,
        BMS_LED_RED   = 2'b01,
        BMS_LED_GREEN = 2'b10
    } bms_led_t;
endpackage : bms_pkg

//--- bms_mem.sv
// Small data memory for the beacon mode sequencer
// Assumes one clock; read data is registered
`timescale 1ns/1ps
`default_nettype none
module bms_mem (
    input  wire logic        ref_clk_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    output var  logic [31:0] rdata_o
);
    logic [31:0] mem_reg [0:15];
    always_ff @(posedge ref_clk_i) begin
        if (we_i) begin
            mem_reg[addr_i] <= wdata_i;
        end
        rdata_o <= mem_reg[addr_i];
    end
endmodule : bms_mem
`default_nettype wire

//--- bms_sequencer.sv
// Beacon mode sequencer with Wishbone registers, mode timers and LED pulser
// Assumes pin inputs are asynchronous; Wishbone master on ref_clk_i
//
// Behaviour
// RULE1: Config timer starts on entering Config mode.
// RULE2: Config timer expiry raises timeout, returns to self-test.
// RULE3: Config timeout length is a software register.
// RULE4: Configuration timeout flashes red twice.
// RULE5: On/off moves Beaconing to Warehouse, Configuration and Warehouse to Beaconing.
// RULE6: On/off entry into Beaconing flashes green once.
// RULE7: On/off exit from Beaconing holds red while the event persists.
// RULE8: On/off exit from Configuration flashes red twice.
// RULE9: Activity event moves Inactivity to Activity; source selectable.
// RULE10: No LED on Activity and Inactivity transitions.
// RULE11: Activity timer starts on entry into Activity.
// RULE12: Activity timer expiry raises timeout and returns to Inactivity.
// RULE13: Activity timeout duration is a software register.
// RULE14: Reset sources: battery insertion, test enable toggle, service request.
// RULE15: Reset event clears data memory and returns to self-test.
// RULE16: After a reset event the self-test LED sequence shows.
// RULE17: Lock disables on/off and forces Beaconing.
// RULE18: Locked device leaves Beaconing only on reset event.
// RULE19: Lock flashes green three times.
// RULE20: Data rate defaults 12.5 Hz; max 200 low power, 1600 high performance.
// RULE21: Range selects 2, 4, 8, 16 g; default 2 g.
// RULE22: Config event from Beaconing or Warehouse enters Config; green twice.
// RULE23: Timer keeps counting during connection; expiry applied at disconnect.
// RULE24: Timers count common tick, compare duration, restart on mode entry.
// RULE25: Counter pulser with fixed on and off time; new pattern replaces old.
//
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "bms_cfg.svh"
module bms_sequencer
    import bms_pkg::*;
#(
    parameter int TICK_DIV  = `BMS_TICK_DIV,
    parameter int FLASH_ON  = `BMS_FLASH_ON_CYC,
    parameter int FLASH_OFF = `BMS_FLASH_OFF_CYC
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    input  wire logic        battery_insert_i,
    input  wire logic        test_enable_i,
    input  wire logic        button_i,
    input  wire logic        config_evt_i,
    input  wire logic        lock_evt_i,
    input  wire logic        connected_i,
    input  wire logic [2:0]  accel_evt_i,
    output var  logic        led_red_o,
    output var  logic        led_green_o,
    output var  logic [2:0]  mode_o,
    output var  logic        cfg_timeout_o,
    output var  logic        act_timeout_o
);
    // --------------------
    // Input synchronisers
    // --------------------
    localparam int NSYNC = 9;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    logic [NSYNC-1:0] prev_reg;
    assign pin_raw = {accel_evt_i, connected_i, lock_evt_i, config_evt_i, button_i,
                      test_enable_i, battery_insert_i};
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg  <= '0;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end
    logic [NSYNC-1:0] rise;
    logic [NSYNC-1:0] fall;
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_edge
            assign rise[gi] = sync2_reg[gi] & ~prev_reg[gi];
            assign fall[gi] = ~sync2_reg[gi] & prev_reg[gi];
        end
    endgenerate
    wire batt_rise   = rise[0];
    wire test_toggle = rise[1] | fall[1];
    wire onoff_rise  = rise[2];
    wire onoff_level = sync2_reg[2];
    wire cfg_rise    = rise[3];
    wire lock_rise   = rise[4];
    wire conn_level  = sync2_reg[5];
    wire conn_fall   = fall[5];
    // --------------------
    // Registers
    // --------------------
    logic [1:0]  act_src_reg;
    logic        svc_reset_reg;
    logic [31:0] cfg_tmo_reg;
    logic [31:0] act_tmo_reg;
    logic [31:0] accel_reg;
    logic [3:0]  mem_addr_reg;
    logic [31:0] mem_rdata;
    bms_mode_t   mode_reg;
    bms_mode_t   mode_next;
    logic        locked_reg;
    logic [31:0] timer_reg;
    logic [31:0] tick_cnt_reg;
    logic [3:0]  clear_cnt_reg;
    logic        cfg_exp_reg;
    logic        act_exp_reg;
    logic        cfg_sticky_reg;
    logic        act_sticky_reg;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Clamp rate to power-mode maximum
    function automatic logic [31:0] legal_accel(input logic [31:0] v);
        logic [31:0] r;
        logic [3:0]  lim;
        r   = v & `BMS_ACC_MASK;
        lim = r[`BMS_ACC_POWER_BIT] ? `BMS_RATE_MAX_HP : `BMS_RATE_MAX_LP;
        if (r[`BMS_ACC_RATE_LSB +: 4] > lim) begin
            r[`BMS_ACC_RATE_LSB +: 4] = lim; // RULE20
        end
        return r;
    endfunction : legal_accel

    // --------------------
    // Wishbone decode
    // --------------------
    wire req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr       = req & wb_we_i;
    wire hit_ctrl = (wb_adr_i == `BMS_OFF_CTRL);
    wire hit_cfg  = (wb_adr_i == `BMS_OFF_CFG_TMO);
    wire hit_act  = (wb_adr_i == `BMS_OFF_ACT_TMO);
    wire hit_acc  = (wb_adr_i == `BMS_OFF_ACCEL);
    wire hit_stat = (wb_adr_i == `BMS_OFF_STATUS);
    wire hit_evt  = (wb_adr_i == `BMS_OFF_EVENT);
    wire hit_madr = (wb_adr_i == `BMS_OFF_MEM_ADDR);
    wire hit_mdat = (wb_adr_i == `BMS_OFF_MEM_DATA);
    wire sw_reset = wr & hit_ctrl & wb_sel_i[0] & wb_dat_i[`BMS_CTRL_SW_RESET];
    wire [31:0] ctrl_wr = merge({30'h0, act_src_reg}, wb_dat_i, wb_sel_i);
    wire [31:0] evt_wr  = wb_dat_i & {30'h0, wb_sel_i[0], wb_sel_i[0]};
    wire [31:0] status_word = {24'h0, locked_reg, act_sticky_reg, cfg_sticky_reg,
                               conn_level, mode_reg, locked_reg};
    logic [31:0] rd_mux;
    always_comb begin
        if (hit_ctrl) begin
            rd_mux = {28'h0, svc_reset_reg, 1'b0, act_src_reg};
        end else if (hit_cfg) begin
            rd_mux = cfg_tmo_reg;
        end else if (hit_act) begin
            rd_mux = act_tmo_reg;
        end else if (hit_acc) begin
            rd_mux = accel_reg;
        end else if (hit_stat) begin
            rd_mux = status_word;
        end else if (hit_evt) begin
            rd_mux = {30'h0, act_sticky_reg, cfg_sticky_reg};
        end else if (hit_madr) begin
            rd_mux = {28'h0, mem_addr_reg};
        end else if (hit_mdat) begin
            rd_mux = mem_rdata;
        end else begin
            rd_mux = 32'h00000000;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_mux : 32'h00000000;
        end
    end
    // --------------------
    // Reset event and memory clear
    // --------------------
    wire reset_evt = batt_rise | test_toggle | svc_reset_reg | sw_reset; // RULE14
    wire clearing  = (mode_reg == BMS_CLEAR);
    wire mem_we    = clearing | (wr & hit_mdat);
    wire [3:0]  mem_addr  = clearing ? clear_cnt_reg : mem_addr_reg;
    wire [31:0] mem_wdata = clearing ? 32'h00000000 : wb_dat_i;
    bms_mem u_mem (
        .ref_clk_i (ref_clk_i),
        .we_i      (mem_we),
        .addr_i    (mem_addr),
        .wdata_i   (mem_wdata),
        .rdata_o   (mem_rdata)
    );
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            act_src_reg   <= 2'h0;
            svc_reset_reg <= 1'b0;
            cfg_tmo_reg   <= `BMS_CFG_TMO_RESET;
            act_tmo_reg   <= `BMS_ACT_TMO_RESET;
            accel_reg     <= `BMS_ACC_RESET; // RULE20 RULE21
            mem_addr_reg  <= 4'h0;
        end else begin
            svc_reset_reg <= wr & hit_ctrl & wb_sel_i[0] & wb_dat_i[`BMS_CTRL_SVC_RESET];
            if (wr & hit_ctrl) begin
                act_src_reg <= ctrl_wr[1:0]; // RULE9
            end
            if (wr & hit_cfg) begin
                cfg_tmo_reg <= merge(cfg_tmo_reg, wb_dat_i, wb_sel_i); // RULE3
            end
            if (wr & hit_act) begin
                act_tmo_reg <= merge(act_tmo_reg, wb_dat_i, wb_sel_i); // RULE13
            end
            if (wr & hit_acc) begin
                accel_reg <= legal_accel(merge(accel_reg, wb_dat_i, wb_sel_i));
            end
            if (wr & hit_madr) begin
                mem_addr_reg <= wb_dat_i[3:0];
            end
        end
    end
    // --------------------
    // Mode timer
    // --------------------
    wire tick       = (tick_cnt_reg == 32'(TICK_DIV - 1));
    wire timed_mode = (mode_reg == BMS_CONFIG) | (mode_reg == BMS_ACTIVE);
    wire [31:0] limit = (mode_reg == BMS_CONFIG) ? cfg_tmo_reg : act_tmo_reg;
    wire timer_hit  = timed_mode & tick & (timer_reg + 32'h1 >= limit); // RULE24
    wire cfg_exp    = cfg_exp_reg | (timer_hit & (mode_reg == BMS_CONFIG));
    wire act_exp    = act_exp_reg | (timer_hit & (mode_reg == BMS_ACTIVE));
    wire cfg_fire   = cfg_exp & ~conn_level; // RULE23
    wire act_fire   = act_exp & ~conn_level; // RULE23
    // --------------------
    // Mode transitions
    // --------------------
    wire act_evt    = sync2_reg[6 + act_src_reg] & (act_src_reg != 2'h3); // RULE9
    wire onoff_ok   = onoff_rise & ~locked_reg; // RULE17
    wire beaconing  = (mode_reg == BMS_INACTIVE) | (mode_reg == BMS_ACTIVE);
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            BMS_CLEAR:     mode_next = (clear_cnt_reg == 4'hF) ? BMS_SELF_TEST : BMS_CLEAR;
            BMS_SELF_TEST: mode_next = BMS_INACTIVE;
            BMS_WAREHOUSE: begin
                if (lock_rise) mode_next = BMS_INACTIVE;
                else if (cfg_rise) mode_next = BMS_CONFIG; // RULE22
                else if (onoff_ok) mode_next = BMS_INACTIVE; // RULE5
            end
            BMS_CONFIG: begin
                if (lock_rise) mode_next = BMS_INACTIVE;
                else if (cfg_fire) mode_next = BMS_SELF_TEST; // RULE2
                else if (onoff_ok) mode_next = BMS_INACTIVE; // RULE5
            end
            BMS_INACTIVE, BMS_ACTIVE: begin
                if (locked_reg) begin
                    if (mode_reg == BMS_INACTIVE && act_evt) mode_next = BMS_ACTIVE; // RULE18
                    else if (act_fire) mode_next = BMS_INACTIVE;
                end
                else if (cfg_rise) mode_next = BMS_CONFIG; // RULE22
                else if (onoff_ok) mode_next = BMS_WAREHOUSE; // RULE5
                else if (mode_reg == BMS_INACTIVE && act_evt) mode_next = BMS_ACTIVE; // RULE9
                else if (mode_reg == BMS_ACTIVE && act_fire) mode_next = BMS_INACTIVE; // RULE12
            end
            default:       mode_next = BMS_CLEAR;
        endcase
        if (reset_evt) mode_next = BMS_CLEAR; // RULE15
    end
    wire entering = (mode_next != mode_reg);
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mode_reg       <= BMS_CLEAR;
            clear_cnt_reg  <= 4'h0;
            locked_reg     <= 1'b0;
            tick_cnt_reg   <= 32'h0;
            timer_reg      <= 32'h0;
            cfg_exp_reg    <= 1'b0;
            act_exp_reg    <= 1'b0;
        end else begin
            mode_reg      <= mode_next;
            clear_cnt_reg <= clearing ? clear_cnt_reg + 4'h1 : 4'h0; // RULE15
            if (reset_evt) locked_reg <= 1'b0;
            else if (lock_rise) locked_reg <= 1'b1; // RULE17
            tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
            if (entering) begin
                timer_reg   <= 32'h0; // RULE1 RULE11
                cfg_exp_reg <= 1'b0;
                act_exp_reg <= 1'b0;
            end else begin
                if (timed_mode & tick & ~timer_hit) timer_reg <= timer_reg + 32'h1;
                cfg_exp_reg <= cfg_exp;
                act_exp_reg <= act_exp;
            end
        end
    end
    // --------------------
    // Timeout flags and pulses
    // --------------------
    wire cfg_to = (mode_reg == BMS_CONFIG) & (mode_next == BMS_SELF_TEST) & ~reset_evt;
    wire act_to = (mode_reg == BMS_ACTIVE) & (mode_next == BMS_INACTIVE) & ~reset_evt;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cfg_timeout_o  <= 1'b0;
            act_timeout_o  <= 1'b0;
            cfg_sticky_reg <= 1'b0;
            act_sticky_reg <= 1'b0;
            mode_o         <= 3'h0;
        end else begin
            cfg_timeout_o  <= cfg_to; // RULE2
            act_timeout_o  <= act_to; // RULE12
            cfg_sticky_reg <= cfg_to | (cfg_sticky_reg & ~(wr & hit_evt & evt_wr[0]));
            act_sticky_reg <= act_to | (act_sticky_reg & ~(wr & hit_evt & evt_wr[1]));
            mode_o         <= mode_reg;
        end
    end
    // --------------------
    // LED pulser
    // --------------------
    logic [2:0]  flash_left_reg;
    logic        flash_red_reg;
    logic        flash_on_reg;
    logic [31:0] flash_cnt_reg;
    logic        start;
    logic        start_red;
    logic [2:0]  start_cnt;
    always_comb begin
        start     = 1'b0;
        start_red = 1'b0;
        start_cnt = 3'h0;
        if (mode_reg == BMS_SELF_TEST && mode_o == BMS_CLEAR) begin
            start = 1'b1; // RULE16
            start_cnt = `BMS_SELFTEST_FLASH;
        end else if (lock_rise & ~reset_evt & ~clearing) begin
            start = 1'b1; // RULE19
            start_cnt = 3'h3;
        end else if (cfg_to) begin
            start = 1'b1; // RULE4
            start_red = 1'b1;
            start_cnt = 3'h2;
        end else if (entering & mode_next == BMS_CONFIG) begin
            start = 1'b1; // RULE22
            start_cnt = 3'h2;
        end else if (entering & mode_reg == BMS_CONFIG & mode_next == BMS_INACTIVE) begin
            start = 1'b1; // RULE8
            start_red = 1'b1;
            start_cnt = 3'h2;
        end else if (entering & mode_reg == BMS_WAREHOUSE & mode_next == BMS_INACTIVE) begin
            start = 1'b1; // RULE6
            start_cnt = 3'h1;
        end
    end
    wire hold_red = (mode_reg == BMS_WAREHOUSE) & onoff_level & ~locked_reg; // RULE7
    wire phase_end = flash_on_reg ? (flash_cnt_reg == 32'(FLASH_ON - 1))
                                  : (flash_cnt_reg == 32'(FLASH_OFF - 1));
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            flash_left_reg <= 3'h0;
            flash_red_reg  <= 1'b0;
            flash_on_reg   <= 1'b0;
            flash_cnt_reg  <= 32'h0;
            led_red_o      <= 1'b0;
            led_green_o    <= 1'b0;
        end else begin
            if (start) begin
                flash_left_reg <= start_cnt; // RULE25
                flash_red_reg  <= start_red;
                flash_on_reg   <= 1'b1;
                flash_cnt_reg  <= 32'h0;
            end else if (flash_left_reg != 3'h0) begin
                flash_cnt_reg <= phase_end ? 32'h0 : flash_cnt_reg + 32'h1;
                if (phase_end) begin
                    flash_on_reg <= ~flash_on_reg;
                    if (~flash_on_reg) flash_left_reg <= flash_left_reg - 3'h1;
                end
            end
            led_red_o   <= hold_red | (flash_red_reg & flash_on_reg & (flash_left_reg != 3'h0));
            led_green_o <= ~flash_red_reg & flash_on_reg & (flash_left_reg != 3'h0); // RULE10
        end
    end
endmodule : bms_sequencer
`default_nettype wire

//--- bms_sequencer_assertions.sv
// Port checks for the beacon mode sequencer
// Assumes bind onto bms_sequencer, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module bms_sequencer_assertions
    import bms_pkg::*;
(
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        led_red_o,
    input wire logic        led_green_o,
    input wire logic [2:0]  mode_o,
    input wire logic        cfg_timeout_o,
    input wire logic        act_timeout_o
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack stuck");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h00000000; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("dat idle");
    property p_cfg_tmo; cfg_timeout_o |-> ##[0:20] mode_o == BMS_SELF_TEST; endproperty
    a_cfg_tmo: assert property (p_cfg_tmo) else $error("cfg tmo");
    property p_cfg_red; cfg_timeout_o |-> ##[0:4] led_red_o; endproperty
    a_cfg_red: assert property (p_cfg_red) else $error("cfg red");
    property p_act_tmo; act_timeout_o |-> ##[0:3] mode_o == BMS_INACTIVE; endproperty
    a_act_tmo: assert property (p_act_tmo) else $error("act tmo");
    property p_act_dark; act_timeout_o |-> !led_red_o && !led_green_o; endproperty
    a_act_dark: assert property (p_act_dark) else $error("act led");
    property p_clear; $fell(rst_i) |-> ##[0:3] mode_o == BMS_CLEAR; endproperty
    a_clear: assert property (p_clear) else $error("clear");
    property p_selftest;
        mode_o == BMS_CLEAR ##1 mode_o != BMS_CLEAR |-> mode_o == BMS_SELF_TEST ##[0:3] led_green_o;
    endproperty
    a_selftest: assert property (p_selftest) else $error("no self test show");
    c_cfg: cover property (cfg_timeout_o);
    c_act: cover property (act_timeout_o);
    c_wh: cover property (mode_o == BMS_WAREHOUSE);
endmodule : bms_sequencer_assertions
bind bms_sequencer bms_sequencer_assertions i_chk (.*);
`default_nettype wire

//--- bms_far_end.sv
// Pin sources: battery, button, sensors, link
// Assumes the bench calls its tasks; pins idle low
`timescale 1ns/1ps
`default_nettype none
module bms_far_end (
    input  wire logic       ref_clk_i,
    output var  logic [8:0] pins_o
);
    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    initial pins_o = 9'h000;
    task automatic ev(input int k, input int n);
        @(posedge ref_clk_i);
        pins_o[k] <= 1'b1;
        repeat (n) @(posedge ref_clk_i);
        pins_o[k] <= 1'b0;
    endtask : ev
endmodule : bms_far_end
`default_nettype wire

//--- tb_bms_sequencer.sv
// Self-checking bench for the beacon mode sequencer
// Assumes short tick and flash parameters
`timescale 1ns/1ps
`default_nettype none
`include "bms_cfg.svh"
module tb_bms_sequencer import bms_pkg::*;;
    // ----------------------------------------
    // Bench
    // ----------------------------------------
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rd;
    wire  logic [31:0] rdat;
    wire  logic        ack, red, grn, cto, ato;
    wire  logic [2:0]  mode;
    wire  logic [8:0]  pins;
    int error_cnt = 0;
    int n_checks = 0;
    initial forever #12.5 ref_clk_i = ~ref_clk_i;
    bms_far_end i_far (.ref_clk_i, .pins_o(pins));
    bms_sequencer #(.TICK_DIV(10), .FLASH_ON(4), .FLASH_OFF(6)) i_dut (.ref_clk_i, .rst_i, .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .battery_insert_i(pins[0]), .test_enable_i(pins[7]), .button_i(pins[1]),
        .config_evt_i(pins[2]), .lock_evt_i(pins[3]), .connected_i(pins[8]), .accel_evt_i(pins[6:4]),
        .led_red_o(red), .led_green_o(grn), .mode_o(mode), .cfg_timeout_o(cto), .act_timeout_o(ato));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge ref_clk_i); while (ack !== 1'b1 && ++n < 50);
        rd = rdat;
        cyc <= 1'b0;
        if (n >= 50) chk(0, 1);
    endtask : wb
    task automatic wait_mode(input logic [2:0] m);
        int n = 0;
        while (mode !== m && n++ < 300) @(posedge ref_clk_i);
        cm(m);
    endtask : wait_mode
    task automatic cm(input logic [2:0] m);
        chk({29'h0, mode}, {29'h0, m});
    endtask : cm
    task automatic flashes(input int len, output int r, output int g);
        logic pr = red, pg = grn;
        {r, g} = '0;
        repeat (len) begin
            @(posedge ref_clk_i);
            r += int'(red && !pr);
            g += int'(grn && !pg);
            {pr, pg} = {red, grn};
        end
    endtask : flashes
    task automatic t_regs();
        logic [31:0] e;
        wb(0, `BMS_OFF_CFG_TMO, 0); chk(rd, `BMS_CFG_TMO_RESET);
        wb(0, `BMS_OFF_ACT_TMO, 0); chk(rd, `BMS_ACT_TMO_RESET);
        wb(0, `BMS_OFF_ACCEL, 0); chk(rd & 32'h30F, {28'h0, `BMS_RATE_12P5});
        for (int r = 0; r < 4; r++) begin
            e = (r << 8) | (r[0] << 4);
            wb(1, `BMS_OFF_ACCEL, e | 32'hF);
            wb(0, `BMS_OFF_ACCEL, 0);
            chk(rd & 32'h31F, e | (r[0] ? `BMS_RATE_MAX_HP : `BMS_RATE_MAX_LP));
        end
        wb(0, 8'h20, 0); chk(rd, 0);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_cfg();
        int r, g, n = 0;
        wb(1, `BMS_OFF_CFG_TMO, 8);
        fork i_far.ev(2, 3); flashes(60, r, g); join
        cm(BMS_CONFIG);
        chk(32'(g), 2);
        while (cto !== 1'b1 && n++ < 200) @(posedge ref_clk_i);
        chk(32'(n >= 10 && n <= 35), 1);
        flashes(60, r, g); chk(32'(r), 2);
        wait_mode(BMS_INACTIVE);
        $display("t_cfg done");
    endtask : t_cfg
    task automatic t_onoff();
        int r, g;
        fork i_far.ev(1, 20); begin repeat (14) @(posedge ref_clk_i); chk(red, 1); end join
        cm(BMS_WAREHOUSE);
        fork i_far.ev(1, 2); flashes(40, r, g); join
        cm(BMS_INACTIVE); chk(32'(g), 1);
        i_far.ev(2, 2); wait_mode(BMS_CONFIG);
        fork i_far.ev(1, 2); flashes(60, r, g); join
        cm(BMS_INACTIVE); chk(32'(r), 2);
        $display("t_onoff done");
    endtask : t_onoff
    task automatic t_act();
        int r, g;
        wb(1, `BMS_OFF_ACT_TMO, 3); wb(1, `BMS_OFF_CTRL, 3);
        i_far.ev(4, 3); repeat (10) @(posedge ref_clk_i); cm(BMS_INACTIVE);
        for (int s = 0; s < 3; s++) begin
            wb(1, `BMS_OFF_CTRL, s);
            fork i_far.ev(4 + s, 3); flashes(20, r, g); join
            cm(BMS_ACTIVE); chk(32'(r + g), 0);
            wait_mode(BMS_INACTIVE);
        end
        fork i_far.ev(8, 60); i_far.ev(6, 3); join cm(BMS_ACTIVE); wait_mode(BMS_INACTIVE);
        $display("t_act done");
    endtask : t_act
    task automatic t_lock();
        int r, g;
        wb(1, `BMS_OFF_MEM_ADDR, 0); wb(1, `BMS_OFF_MEM_DATA, 32'hA5);
        wb(0, `BMS_OFF_MEM_DATA, 0); chk(rd, 32'hA5);
        fork i_far.ev(3, 2); flashes(60, r, g); join
        chk(32'(g), 3); cm(BMS_INACTIVE);
        i_far.ev(1, 2); i_far.ev(2, 2); repeat (20) @(posedge ref_clk_i);
        cm(BMS_INACTIVE);
        i_far.ev(7, 2); wait_mode(BMS_CLEAR); wait_mode(BMS_INACTIVE);
        wb(1, `BMS_OFF_MEM_ADDR, 0); wb(0, `BMS_OFF_MEM_DATA, 0); chk(rd, 0);
        i_far.ev(0, 2); wait_mode(BMS_CLEAR); wait_mode(BMS_INACTIVE);
        wb(1, `BMS_OFF_CTRL, 32'h8); wait_mode(BMS_CLEAR); wait_mode(BMS_INACTIVE);
        $display("t_lock done");
    endtask : t_lock
    task automatic complete_run();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    initial begin
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        wait_mode(BMS_INACTIVE);
        t_regs();
        t_cfg();
        t_onoff();
        t_act();
        t_lock();
        complete_run();
    end
    initial begin
        repeat (30000) @(posedge ref_clk_i);
        error_cnt++;
        complete_run();
    end
endmodule : tb_bms_sequencer
`default_nettype wire
